// [ogc_cfg.svh]
`ifndef OGC_CFG_SVH
`define OGC_CFG_SVH

// Core clock rate and the calibrate lead time before chip select may fall.
`define OGC_CLK_MHZ              100
`define OGC_CALIBRATE_LEAD_NS    10
// The lead time is a least time, so it is rounded up to whole core cycles.
`define OGC_CALIBRATE_LEAD_CYC   (((`OGC_CALIBRATE_LEAD_NS * `OGC_CLK_MHZ) + 999) / 1000)

// Serial clock counts within one chip-select frame.
`define OGC_CONV_SCLKS           6'h13
`define OGC_WRITE_SCLKS          6'h11
`define OGC_SHIFT_SCLKS          6'h10
`define OGC_EDGE_MAX             6'h3f
`define OGC_LEAD_MAX             8'hff

// Register addresses carried in the first four bits of a write.
`define OGC_ADDR_CONTROL         4'h1
`define OGC_ADDR_OFFSET_A        4'h2
`define OGC_ADDR_OFFSET_B        4'h3
`define OGC_ADDR_GAIN_A          4'h4
`define OGC_ADDR_GAIN_B          4'h5

// Field positions.
`define OGC_CTRL_CAL_BIT         0
`define OGC_GAIN_MSB             11
`define OGC_GAIN_LSB             5
`define OGC_OFFSET_SIGN          11

// Reset values and arithmetic constants.
`define OGC_REG_RESET            12'h000
`define OGC_GAIN_RESET           7'h00
`define OGC_GAIN_UNITY           14'sh1000
`define OGC_GAIN_SHIFT           12
`define OGC_OFFSET_LIMIT         12'h080
`define OGC_CODE_MAX             15'sh07ff
`define OGC_CODE_MIN             15'sh7800

`endif

// [ogc_pkg.sv]
`include "ogc_cfg.svh"

package ogc_pkg;

	typedef enum logic [1:0] {OGC_IDLE, OGC_CONV, OGC_CAL, OGC_DONE} ogc_phase_type;

	typedef struct packed {
		logic [11:0] control;
		logic [11:0] channel_a_offset;
		logic [11:0] channel_b_offset;
		logic [6:0]  channel_a_gain_trim;
		logic [6:0]  channel_b_gain_trim;
	} ogc_regs_type;

	typedef struct packed {
		logic [11:0] a;
		logic [11:0] b;
	} ogc_result_type;

	typedef struct packed {
		logic           cs_s1, cs_s2, cs_d;
		logic           sclk_s1, sclk_s2, sclk_d;
		logic           din_s1, din_s2;
		logic           cal_s1, cal_s2, cal_d;
		ogc_phase_type  phase;
		logic [5:0]     edge_cnt;
		logic [15:0]    shift;
		logic [7:0]     lead_cnt;
		logic           cal_active, cal_done, cal_inacc;
		logic           corrupt, res_valid, res_corrupt;
		ogc_result_type res;
		ogc_regs_type   regs;
	} ogc_state_type;

endpackage

// [ogc_calib.sv]
`timescale 1ns/100ps
// Functional notes
// - Calibrate pin high starts calibration at CS fall.
// - Calibration lasts CS fall plus 19 clocks.
// - Pin held high keeps calibrating every frame.
// - Short lead time spoils only that calibration.
// - Pin rising mid conversion corrupts that result.
// - Calibration complete after the 19th clock.
// - First frame after pin low converts normally.
// - Control calibrate bit starts calibration, corrupts current.
// - Shorted-input codes stored, subtracted from results.
// - Gain change keeps old offset until recalibrated.
// - Offset correction spans plus or minus 128 from calibration; host writes are unclamped.
// - Offset registers are 12 bits, host writable.
// - Each channel owns its gain trim register.
// - Gain trim scales result by one plus-minus x/4096.
// - Sign zero subtracts, sign one adds factor.
// - All-zero gain trim multiplies by one.
// - Write is 4 address, 12 data, commit clock.
// - Addresses 2,3 offsets; 4,5 gain trims.
// - Gain writes keep seven bits after address.
// - Reset clears every register to zero.
module ogc_calib
	import ogc_pkg::*;
#(
	parameter int unsigned P_LEAD_CYC = `OGC_CALIBRATE_LEAD_CYC
) (
	input  wire logic        i_core_clk,            // Core clock, 100 MHz.
	input  wire logic        i_srst,                // Synchronous reset, active high.
	input  wire logic        i_cs_n,                // Chip select pin, active low.
	input  wire logic        i_sclk,                // Serial clock pin.
	input  wire logic        i_serial_data_input,   // Serial data pin.
	input  wire logic        i_cal_pin,             // Calibrate pin, active high.
	input  wire logic [11:0] i_conv_a,              // Raw channel A code from converter.
	input  wire logic [11:0] i_conv_b,              // Raw channel B code from converter.
	output logic             o_cal_active,          // Inputs shorted, calibrating.
	output logic             o_cal_done,            // Calibration frame finished.
	output logic             o_cal_inaccurate,      // Current calibration is spoiled.
	output logic             o_result_valid,        // Corrected result ready.
	output logic             o_result_corrupt,      // Frame result is corrupted.
	output ogc_result_type   o_result,              // Corrected result pair.
	output ogc_regs_type     o_regs                 // Register contents.
);

	ogc_state_type st;
	ogc_state_type next_st;
	logic          cs_fall;
	logic          cs_rise;
	logic          cal_rise;
	logic          sclk_fall;
	logic          sclk_cnt_fall;
	logic [5:0]    cnt_n;
	logic [11:0]   wr_data;

	// Offset subtraction works in sign-magnitude, so the measured code is folded.
	function automatic logic [11:0] ogc_to_sm(input logic [11:0] raw);
		logic [11:0] mag;
		mag = raw[11] ? (12'h000 - raw) : raw;
		if (mag > `OGC_OFFSET_LIMIT) begin
			mag = `OGC_OFFSET_LIMIT;
		end
		return {raw[11], mag[10:0]};
	endfunction

	// Gain first, then offset, then clamp, so a trimmed full scale cannot wrap.
	function automatic logic [11:0] ogc_correct(input logic [11:0] raw,
	                                            input logic [6:0]  gain,
	                                            input logic [11:0] off);
		logic signed [13:0] mult;
		logic signed [25:0] prod;
		logic signed [14:0] val;
		logic signed [14:0] offs;
		mult = gain[6] ? (`OGC_GAIN_UNITY + $signed({8'h00, gain[5:0]}))
		               : (`OGC_GAIN_UNITY - $signed({8'h00, gain[5:0]}));
		prod = $signed(raw) * mult;
		val  = 15'(prod >>> `OGC_GAIN_SHIFT);
		offs = off[`OGC_OFFSET_SIGN] ? -$signed({4'h0, off[10:0]})
		                             : $signed({4'h0, off[10:0]});
		val  = val - offs;
		if (val > `OGC_CODE_MAX) begin
			val = `OGC_CODE_MAX;
		end else if (val < $signed(`OGC_CODE_MIN)) begin
			val = $signed(`OGC_CODE_MIN);
		end
		return val[11:0];
	endfunction

	// Edge detection only looks at the second synchroniser stage and later.
	assign cs_fall       = st.cs_d & ~st.cs_s2;
	assign cs_rise       = ~st.cs_d & st.cs_s2;
	assign cal_rise      = st.cal_s2 & ~st.cal_d;
	assign sclk_fall     = st.sclk_d & ~st.sclk_s2;
	// A clock edge landing with the chip-select fall is not counted.
	assign sclk_cnt_fall = sclk_fall & ~st.cs_s2 & ~st.cs_d & (st.phase != OGC_IDLE);
	assign cnt_n         = st.edge_cnt + 6'h01;
	assign wr_data       = st.shift[11:0];

	// Next-state logic for the whole block.
	always_comb begin
		next_st             = st;
		next_st.cs_s1       = i_cs_n;
		next_st.cs_s2       = st.cs_s1;
		next_st.cs_d        = st.cs_s2;
		next_st.sclk_s1     = i_sclk;
		next_st.sclk_s2     = st.sclk_s1;
		next_st.sclk_d      = st.sclk_s2;
		next_st.din_s1      = i_serial_data_input;
		next_st.din_s2      = st.din_s1;
		next_st.cal_s1      = i_cal_pin;
		next_st.cal_s2      = st.cal_s1;
		next_st.cal_d       = st.cal_s2;
		next_st.cal_done    = 1'b0;
		next_st.res_valid   = 1'b0;
		next_st.res_corrupt = 1'b0;

		// Lead timer measures how long the pin has been high before chip select falls.
		if (!st.cal_s2) begin
			next_st.lead_cnt = 8'h00;
		end else if (st.lead_cnt != `OGC_LEAD_MAX) begin
			next_st.lead_cnt = st.lead_cnt + 8'h01;
		end

		// A pin rising mid conversion spoils the samples already taken.
		if (cal_rise && st.phase == OGC_CONV) begin
			next_st.corrupt = 1'b1;
		end

		if (cs_rise) begin
			next_st.phase      = OGC_IDLE;
			next_st.cal_active = 1'b0;
		end else if (cs_fall) begin
			next_st.edge_cnt = 6'h00;
			next_st.shift    = 16'h0000;
			next_st.corrupt  = 1'b0;
			if (st.cal_s2 || st.regs.control[`OGC_CTRL_CAL_BIT]) begin
				// The host must keep both converters powered through this frame.
				next_st.phase      = OGC_CAL;
				next_st.cal_active = 1'b1;
				next_st.cal_inacc  = st.cal_s2 && (st.lead_cnt < 8'(P_LEAD_CYC));
				next_st.regs.control[`OGC_CTRL_CAL_BIT] = 1'b0;
			end else begin
				next_st.phase      = OGC_CONV;
				next_st.cal_active = 1'b0;
				next_st.cal_inacc  = 1'b0;
			end
		end else if (sclk_cnt_fall) begin
			if (st.edge_cnt != `OGC_EDGE_MAX) begin
				next_st.edge_cnt = cnt_n;
			end
			// Address and data bits arrive MSB first on the first sixteen edges.
			if (cnt_n <= `OGC_SHIFT_SCLKS) begin
				next_st.shift = {st.shift[14:0], st.din_s2};
			end
			// The seventeenth edge commits the write to the addressed register.
			if (cnt_n == `OGC_WRITE_SCLKS) begin
				case (st.shift[15:12])
					`OGC_ADDR_CONTROL: begin
						next_st.regs.control = wr_data;
						if (wr_data[`OGC_CTRL_CAL_BIT] && st.phase == OGC_CONV) begin
							next_st.corrupt = 1'b1;
						end
					end
					`OGC_ADDR_OFFSET_A: begin
						next_st.regs.channel_a_offset = wr_data;
					end
					`OGC_ADDR_OFFSET_B: begin
						next_st.regs.channel_b_offset = wr_data;
					end
					`OGC_ADDR_GAIN_A: begin
						next_st.regs.channel_a_gain_trim =
							wr_data[`OGC_GAIN_MSB:`OGC_GAIN_LSB];
					end
					`OGC_ADDR_GAIN_B: begin
						next_st.regs.channel_b_gain_trim =
							wr_data[`OGC_GAIN_MSB:`OGC_GAIN_LSB];
					end
					default: begin
					end
				endcase
			end
			// The nineteenth edge ends the conversion or calibration frame.
			if (cnt_n == `OGC_CONV_SCLKS) begin
				case (st.phase)
					OGC_CONV: begin
						next_st.res_valid   = ~next_st.corrupt;
						next_st.res_corrupt = next_st.corrupt;
						next_st.res.a = ogc_correct(i_conv_a, st.regs.channel_a_gain_trim,
						                            st.regs.channel_a_offset);
						next_st.res.b = ogc_correct(i_conv_b, st.regs.channel_b_gain_trim,
						                            st.regs.channel_b_offset);
						next_st.phase = OGC_DONE;
					end
					OGC_CAL: begin
						next_st.cal_done   = 1'b1;
						next_st.cal_active = 1'b0;
						next_st.phase      = OGC_DONE;
						// A spoiled measurement is dropped; the old offset stays in use.
						if (!st.cal_inacc) begin
							next_st.regs.channel_a_offset = ogc_to_sm(i_conv_a);
							next_st.regs.channel_b_offset = ogc_to_sm(i_conv_b);
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// State register; chip select rests high so no false edge follows reset.
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			st         <= '0;
			st.cs_s1   <= 1'b1;
			st.cs_s2   <= 1'b1;
			st.cs_d    <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs come straight from the state register.
	assign o_cal_active     = st.cal_active;
	assign o_cal_done       = st.cal_done;
	assign o_cal_inaccurate = st.cal_inacc;
	assign o_result_valid   = st.res_valid;
	assign o_result_corrupt = st.res_corrupt;
	assign o_result         = st.res;
	assign o_regs           = st.regs;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_srst);

	// Frame openings as seen one cycle after the sampled chip-select fall.
	sequence s_cal_open;
		##1 (st.phase == OGC_CAL) && st.cal_active;
	endsequence

	sequence s_conv_open;
		##1 (st.phase == OGC_CONV) && !st.cal_active;
	endsequence

	sequence s_nineteenth;
		sclk_cnt_fall && (st.edge_cnt == 6'h12);
	endsequence

	sequence s_commit;
		sclk_cnt_fall && (st.edge_cnt == 6'h10);
	endsequence

	a_cal_pin_start: assert property (
		cs_fall && st.cal_s2 |-> s_cal_open)
		else $error("Calibrate pin did not start a calibration frame.");

	a_cal_keep_going: assert property (
		cs_fall && st.cal_s2 && (st.phase == OGC_IDLE) && $past(st.cal_s2)
		|-> s_cal_open)
		else $error("Held calibrate pin did not repeat calibration.");

	a_cal_frame_length: assert property (
		st.cal_done |-> $past(st.phase) == OGC_CAL && $past(st.edge_cnt) == 6'h12
		&& $past(sclk_cnt_fall))
		else $error("Calibration ended on the wrong serial clock.");

	a_cal_complete: assert property (
		(st.phase == OGC_CAL) and s_nineteenth |=> st.cal_done && !st.cal_active
		&& (st.phase == OGC_DONE))
		else $error("Calibration not complete after the last clock.");

	a_lead_short: assert property (
		cs_fall && st.cal_s2 && (st.lead_cnt < 8'(P_LEAD_CYC)) |=> st.cal_inacc)
		else $error("Short lead time not flagged as inaccurate.");

	a_mid_conv_corrupt: assert property (
		cal_rise && (st.phase == OGC_CONV) && !cs_rise |=> st.corrupt
		##0 (!st.res_valid) [*2])
		else $error("Calibrate rise during conversion not marked corrupt.");

	a_normal_after_low: assert property (
		cs_fall && !st.cal_s2 && !st.regs.control[`OGC_CTRL_CAL_BIT] |-> s_conv_open)
		else $error("Normal conversion not started with pin low.");

	a_cal_bit_start: assert property (
		cs_fall && st.regs.control[`OGC_CTRL_CAL_BIT]
		|=> (st.phase == OGC_CAL) && !st.regs.control[`OGC_CTRL_CAL_BIT])
		else $error("Control calibrate bit did not start calibration.");

	a_offset_store: assert property (
		st.cal_done && !st.cal_inacc
		|-> st.regs.channel_a_offset == ogc_to_sm($past(i_conv_a))
		&& st.regs.channel_b_offset == ogc_to_sm($past(i_conv_b)))
		else $error("Measured offset not stored.");

	a_offset_range: assert property (
		st.cal_done && !st.cal_inacc |-> st.regs.channel_a_offset[10:0] <= 11'h080)
		else $error("Calibrated offset exceeds the correction range.");

	a_result_math: assert property (
		st.res_valid |-> st.res.a == ogc_correct($past(i_conv_a),
		$past(st.regs.channel_a_gain_trim), $past(st.regs.channel_a_offset)))
		else $error("Corrected result does not match gain and offset.");

	a_write_offset: assert property (
		sclk_cnt_fall && (st.edge_cnt == 6'h10) && (st.shift[15:12] == `OGC_ADDR_OFFSET_A)
		|=> st.regs.channel_a_offset == $past(st.shift[11:0]))
		else $error("Offset write not committed on the seventeenth clock.");

	a_write_gain: assert property (
		sclk_cnt_fall && (st.edge_cnt == 6'h10) && (st.shift[15:12] == `OGC_ADDR_GAIN_B)
		|=> st.regs.channel_b_gain_trim == $past(st.shift[11:5]))
		else $error("Gain trim write did not keep the seven leading bits.");

	a_reset_clear: assert property (
		@(posedge i_core_clk) disable iff (1'b0)
		$past(i_srst) |-> (st.regs == '0) && !st.res_valid && !st.cal_active)
		else $error("Registers not cleared by reset.");

	a_offset_range_b: assert property (
		st.cal_done && !st.cal_inacc |-> st.regs.channel_b_offset[10:0] <= 11'h080)
		else $error("Calibrated channel B offset exceeds the correction range.");

	a_control_corrupt: assert property (
		s_commit ##0 ((st.shift[15:12] == `OGC_ADDR_CONTROL) && st.shift[0]
		&& (st.phase == OGC_CONV)) |=> st.corrupt)
		else $error("Calibrate bit write did not corrupt the running conversion.");

	a_gain_keep_other: assert property (
		s_commit ##0 (st.shift[15:12] == `OGC_ADDR_GAIN_A) |=> $stable(st.regs.channel_b_gain_trim)
		&& (st.regs.channel_a_gain_trim == $past(st.shift[11:5])))
		else $error("Gain trim write leaked into the other channel.");

	a_offset_hold: assert property (
		(st.phase == OGC_CONV) && !(sclk_cnt_fall && (cnt_n == `OGC_WRITE_SCLKS))
		|=> $stable(st.regs.channel_a_offset) && $stable(st.regs.channel_b_offset))
		else $error("Stored offset changed during a normal conversion.");

	a_lead_ok: assert property (
		cs_fall && st.cal_s2 && (st.lead_cnt >= 8'(P_LEAD_CYC)) |=> !st.cal_inacc)
		else $error("Calibration with enough lead flagged as inaccurate.");

	a_cut_frame_idle: assert property (
		cs_rise |=> (st.phase == OGC_IDLE) && !st.cal_active)
		else $error("Chip select rise did not close the frame.");

endmodule

// [ogc_host_model.sv]
`timescale 1ns/100ps
// Host side of the serial link; every pin moves just after a falling core edge.
module ogc_host_model (
	input  wire logic i_core_clk, // Core clock that paces the pins.
	output logic      o_cs_n,     // Chip select, active low.
	output logic      o_sclk,     // Serial clock, idles high between frames.
	output logic      o_din,      // Serial data input of the block.
	output logic      o_cal       // Calibrate pin, active high.
);
	// All pins idle from time zero, chip select deasserted.
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b1;
		o_din  = 1'b0;
		o_cal  = 1'b0;
	end

	// Called only between frames, so a normal run never spoils a conversion.
	task automatic set_cal(input logic v);
		@(negedge i_core_clk) o_cal = v;
	endtask

	// One frame of 19 clocks; mid raises the pin just after the tenth clock fall, which only a test asks for.
	task automatic frame(input logic [3:0] addr, input logic [11:0] data, input bit mid);
		logic [18:0] bits;
		bits = {addr, data, 3'h0};
		@(negedge i_core_clk) o_cs_n = 1'b0;
		for (int i = 18; i >= 0; i--) begin
			o_din = bits[i];
			repeat (4) @(negedge i_core_clk);
			o_sclk = ~o_sclk;
			if (mid && i == 9)
				o_cal = 1'b1;
			repeat (4) @(negedge i_core_clk);
			o_sclk = ~o_sclk;
		end
		repeat (4) @(negedge i_core_clk);
		// Converters stay powered throughout; a released data line must not look valid.
		o_cs_n = 1'b1;
		o_din = ~o_din;
		repeat (8) @(negedge i_core_clk);
	endtask
endmodule

// [adc_offset_gain_calibration_bench.sv]
`timescale 1ns/100ps
module adc_offset_gain_calibration_bench;
	import ogc_pkg::*;
	logic           core_clk, srst, cs_n, sclk, din, cal;
	logic [11:0]    conv_a, conv_b;
	logic           cal_active, cal_done, cal_inaccurate, result_valid, result_corrupt;
	ogc_result_type result, got;
	ogc_regs_type   regs;
	logic           seen_valid, seen_corrupt, seen_done, seen_active, seen_clr;
	int             miscompares, n_tests;

	ogc_host_model i_ogc_host_model (.i_core_clk(core_clk), .o_cs_n(cs_n), .o_sclk(sclk),
		.o_din(din), .o_cal(cal));

	// A longer lead than default gives the short-lead case a clear margin.
	ogc_calib #(.P_LEAD_CYC(4)) i_ogc_calib (.i_core_clk(core_clk), .i_srst(srst),
		.i_cs_n(cs_n), .i_sclk(sclk), .i_serial_data_input(din), .i_cal_pin(cal),
		.i_conv_a(conv_a), .i_conv_b(conv_b), .o_cal_active(cal_active),
		.o_cal_done(cal_done), .o_cal_inaccurate(cal_inaccurate),
		.o_result_valid(result_valid), .o_result_corrupt(result_corrupt),
		.o_result(result), .o_regs(regs));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Pulses last one cycle, so they are latched here and judged after the frame.
	// Clearing happens here too, so each latch has a single driving process.
	always @(posedge core_clk) begin
		if (seen_clr) begin
			{seen_valid, seen_corrupt, seen_done, seen_active} <= 4'h0;
		end else begin
			seen_valid   <= seen_valid | result_valid;
			seen_corrupt <= seen_corrupt | result_corrupt;
			seen_done    <= seen_done | cal_done;
			seen_active  <= seen_active | cal_active;
		end
		if (result_valid)
			got <= result;
	end

	task automatic check_val(input logic [63:0] g, input logic [63:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Corrected code: gain first with floor, then offset, then clamp to 12 bits.
	function automatic logic [11:0] expect_code(logic [11:0] raw, logic [6:0] g,
		logic [11:0] off);
		int r, m, p;
		r = $signed(raw);
		m = g[5:0];
		m = g[6] ? 4096 + m : 4096 - m;
		p = (r * m) >>> 12;
		p = off[11] ? p + off[10:0] : p - off[10:0];
		if (p > 2047)
			p = 2047;
		if (p < -2048)
			p = -2048;
		return p[11:0];
	endfunction

	task automatic check_res(input logic [11:0] a, b, input logic [6:0] ga, gb,
		input logic [11:0] oa, ob);
		check_val(got, {expect_code(a, ga, oa), expect_code(b, gb, ob)});
	endtask

	task automatic run(input logic [3:0] addr, input logic [11:0] data, input bit mid,
		input logic [11:0] a, b);
		@(negedge core_clk);
		conv_a = a;
		conv_b = b;
		seen_clr = 1'b1;
		@(negedge core_clk);
		seen_clr = 1'b0;
		i_ogc_host_model.frame(addr, data, mid);
	endtask

	task automatic end_test(input string name);
		$display("test %s finished", name);
	endtask

	task automatic test_plain();
		check_val(regs, 50'h0);
		run(4'h0, 12'h000, 1'b0, 12'h123, 12'hedc);
		check_val({seen_valid, seen_corrupt, seen_done}, 3'h4);
		check_val(got, 24'h123edc);
		end_test("plain");
	endtask

	task automatic test_offsets();
		run(4'h2, 12'h010, 1'b0, 12'h000, 12'h000);
		run(4'h3, 12'h810, 1'b0, 12'h000, 12'h000);
		check_val(regs, {24'h000010, 12'h810, 14'h0});
		run(4'h0, 12'h000, 1'b0, 12'h100, 12'hf00);
		check_res(12'h100, 12'hf00, 7'h00, 7'h00, 12'h010, 12'h810);
		end_test("offsets");
	endtask

	task automatic test_gain();
		run(4'h4, {7'h7f, 5'h00}, 1'b0, 12'h000, 12'h000);
		run(4'h5, {7'h3f, 5'h00}, 1'b0, 12'h000, 12'h000);
		run(4'h6, 12'hfff, 1'b0, 12'h000, 12'h000);
		check_val(regs, {24'h000010, 12'h810, 14'h3fbf});
		run(4'h0, 12'h000, 1'b0, 12'h7ff, 12'h800);
		check_res(12'h7ff, 12'h800, 7'h7f, 7'h3f, 12'h010, 12'h810);
		run(4'h4, 12'h000, 1'b0, 12'h000, 12'h000);
		run(4'h5, 12'h000, 1'b0, 12'h000, 12'h000);
		check_val(regs, {24'h000010, 12'h810, 14'h0});
		end_test("gain");
	endtask

	task automatic test_cal_pin();
		i_ogc_host_model.set_cal(1'b1);
		repeat (10) @(negedge core_clk);
		run(4'h0, 12'h000, 1'b0, 12'h005, 12'hffb);
		check_val({seen_done, seen_active, seen_valid, cal_inaccurate}, 4'hc);
		check_val(regs, {12'h000, 12'h005, 12'h805, 14'h0});
		run(4'h0, 12'h000, 1'b0, 12'h0c8, 12'hf38);
		check_val({seen_done, regs}, {1'b1, 12'h000, 12'h080, 12'h880, 14'h0});
		i_ogc_host_model.set_cal(1'b0);
		run(4'h0, 12'h000, 1'b0, 12'h100, 12'h100);
		check_val({seen_done, seen_valid}, 2'h1);
		check_res(12'h100, 12'h100, 7'h00, 7'h00, 12'h080, 12'h880);
		end_test("cal_pin");
	endtask

	task automatic test_short_lead();
		i_ogc_host_model.set_cal(1'b1);
		run(4'h0, 12'h000, 1'b0, 12'h007, 12'h007);
		check_val({cal_inaccurate, regs}, {1'b1, 12'h000, 12'h080, 12'h880, 14'h0});
		run(4'h0, 12'h000, 1'b0, 12'h007, 12'h007);
		check_val({cal_inaccurate, regs}, {1'b0, 12'h000, 12'h007, 12'h007, 14'h0});
		i_ogc_host_model.set_cal(1'b0);
		end_test("short_lead");
	endtask

	task automatic test_spoiled();
		run(4'h0, 12'h000, 1'b1, 12'h123, 12'h123);
		check_val({seen_valid, seen_corrupt}, 2'h1);
		i_ogc_host_model.set_cal(1'b0);
		run(4'h0, 12'h000, 1'b0, 12'h123, 12'h123);
		check_val({seen_valid, seen_corrupt, seen_done}, 3'h4);
		run(4'h1, 12'h001, 1'b0, 12'h000, 12'h000);
		check_val({seen_valid, seen_corrupt}, 2'h1);
		run(4'h0, 12'h000, 1'b0, 12'h00a, 12'h000);
		check_val({seen_done, regs}, {1'b1, 12'h000, 12'h00a, 12'h000, 14'h0});
		end_test("spoiled");
	endtask

	// A second reset mid run must clear written state and leave the link usable.
	task automatic test_reset();
		@(negedge core_clk) srst = 1'b1;
		repeat (2) @(negedge core_clk);
		check_val(regs, 50'h0);
		check_val({result, result_valid, cal_active, cal_inaccurate}, 27'h0);
		srst = 1'b0;
		repeat (4) @(negedge core_clk);
		run(4'h0, 12'h000, 1'b0, 12'h055, 12'h0aa);
		check_val({seen_valid, seen_corrupt, seen_done}, 3'h4);
		check_val(got, 24'h0550aa);
		end_test("reset");
	endtask

	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Main sequence: two reset cycles, then settle time for the pin synchronisers.
	initial begin
		srst = 1'b1;
		conv_a = 12'h000;
		conv_b = 12'h000;
		miscompares = 0;
		n_tests = 0;
		seen_clr = 1'b0;
		repeat (2) @(negedge core_clk);
		srst = 1'b0;
		repeat (6) @(negedge core_clk);
		test_plain();
		test_offsets();
		test_gain();
		test_cal_pin();
		test_short_lead();
		test_spoiled();
		test_reset();
		report_and_stop();
	end

	// A hang counts as a mismatch and still ends in the closing report.
	initial begin
		#1000000;
		miscompares++;
		report_and_stop();
	end
endmodule
